// File: hdl/ela_top.sv
// embedded logic analyzer: ahb-lite registers, trigger sequencer, capture
`timescale 1ns/1ps
module ela_top (
	input  wire logic                       hclk,
	input  wire logic                       hresetn,
	input  wire logic                       hsel,
	input  wire logic [31:0]                haddr,
	input  wire logic [1:0]                 htrans,
	input  wire logic                       hwrite,
	input  wire logic [2:0]                 hsize,
	input  wire logic [31:0]                hwdata,
	input  wire logic                       hready,
	output logic                            hreadyout,
	output logic                            hresp,
	output logic      [31:0]                hrdata,
	input  wire logic [ela_pkg::CAP_W-1:0]  probe,
	output logic      [ela_pkg::STIM_W-1:0] stim,
	output logic                            stim_valid
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		ela_pkg::ela_trig_cfg_t [2:0]  tcfg;
		logic [1:0]                    ntrig;
		logic [1:0]                    pre;
		logic [ela_pkg::STIM_W-1:0]    stim_cfg;
		logic [ela_pkg::AW-1:0]        rd_adr;
		ela_pkg::ela_cap_t             st;
		logic [ela_pkg::AW-1:0]        wp;
		logic [10:0]                   cnt;
		logic [1:0]                    stage;
		logic [ela_pkg::CAP_W-1:0]     prev;
		logic [ela_pkg::AW-1:0]        tpos;
		logic                          trig;
		logic                          mism;
		logic [ela_pkg::STIM_W-1:0]    stim;
		logic                          stim_vld;
		logic                          wr_pend;
		logic [7:0]                    adr;
		logic [1:0]                    rd_wait;
		logic [31:0]                   hrdata;
		logic                          hready;
	} ela_top_st_t;

	ela_top_st_t               s;
	ela_top_st_t               n;
	logic                      arm;
	logic                      we;
	logic [2:0]                adec;
	logic [10:0]               pre_n;
	logic [1:0]                last;
	logic [ela_pkg::NSTG-1:0]  tm;
	logic                      hit;
	logic                      mark;
	logic [ela_pkg::AW-1:0]    raddr;
	logic [ela_pkg::CAP_W-1:0] mem_rd;
	logic [31:0]               rdv;

	// ------------------------------------------------------------
	// decoding helpers
	// ------------------------------------------------------------
	// {valid, stage} of a trigger pattern register
	function automatic logic [2:0] trig_dec(input logic [7:0] a);
		logic [7:0] o;
		o = a - ela_pkg::A_TRIG;
		trig_dec = {(a >= ela_pkg::A_TRIG) && (o < ela_pkg::TRIG_SPAN)
			&& (a[3:2] != 2'h3), o[5:4]};
	endfunction

	function automatic logic [10:0] pre_cnt(input logic [1:0] c);
		pre_cnt = 11'(c) * ela_pkg::QUARTER;
	endfunction

	assign adec = trig_dec(s.adr);
	assign pre_n = pre_cnt(s.pre);
	// zero stages is treated as one
	assign last = (s.ntrig == 2'h0) ? 2'h0 : s.ntrig - 2'h1;
	assign hit = tm[s.stage];
	assign mark = (pre_n != 11'h0) && ({1'b0, s.rd_adr} < pre_n);
	// readback index 0 is the oldest pre-trigger sample
	assign raddr = s.tpos - pre_n[ela_pkg::AW-1:0] + s.rd_adr;

	// ------------------------------------------------------------
	// trigger comparators and trace buffer
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < ela_pkg::NSTG; g++)
		begin : g_stage
			ela_trig_stage u_stage (
				.cfg   (s.tcfg[g]),
				.probe (probe),
				.prev  (s.prev),
				.match (tm[g])
			);
		end
	endgenerate

	ela_trace_mem u_mem (
		.clk   (hclk),
		.we    (we),
		.waddr (s.wp),
		.wdata (probe),
		.raddr (raddr),
		.rdata (mem_rd)
	);

	// ------------------------------------------------------------
	// register read mux
	// ------------------------------------------------------------
	always_comb
	begin
		rdv = '0;
		case (s.adr)
			ela_pkg::A_CTRL:
			begin
				rdv[ela_pkg::C_NTRIG +: 2] = s.ntrig;
				rdv[ela_pkg::C_PRE +: 2] = s.pre;
				for (int i = 0; i < ela_pkg::NSTG; i++)
					rdv[ela_pkg::C_AND + i] = s.tcfg[i].and_mode;
			end
			ela_pkg::A_STAT:
			begin
				rdv[ela_pkg::S_BUSY] = s.st inside {ela_pkg::ELA_FILL,
					ela_pkg::ELA_HUNT, ela_pkg::ELA_POST};
				rdv[ela_pkg::S_TRIG] = s.trig;
				rdv[ela_pkg::S_DONE] = (s.st == ela_pkg::ELA_DONE);
				rdv[ela_pkg::S_MISM] = s.mism;
				rdv[ela_pkg::S_MARK] = mark;
				rdv[ela_pkg::S_STAGE +: 2] = s.stage;
			end
			ela_pkg::A_REQD: rdv = ela_pkg::DEPTH_W;
			ela_pkg::A_TPOS:
			begin
				rdv[ela_pkg::AW-1:0] = s.tpos;
				rdv[ela_pkg::T_IDX +: 11] = pre_n;
			end
			ela_pkg::A_STIM: rdv = s.stim_cfg;
			ela_pkg::A_RADR: rdv[ela_pkg::AW-1:0] = s.rd_adr;
			ela_pkg::A_RDAT: rdv = mem_rd;
			default:
				if (adec[2])
				begin
					case (s.adr[3:2])
						ela_pkg::SUB_CARE: rdv = s.tcfg[adec[1:0]].care;
						ela_pkg::SUB_EDGE: rdv = s.tcfg[adec[1:0]].edge_en;
						default: rdv = s.tcfg[adec[1:0]].val;
					endcase
				end
		endcase
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		n = s;
		arm = 1'b0;
		we = 1'b0;
		n.stim_vld = 1'b0;
		n.prev = probe;
		n.wr_pend = 1'b0;

		// write data phase: hwdata stands this cycle
		if (s.wr_pend)
		begin
			case (s.adr)
				ela_pkg::A_CTRL:
				begin
					arm = hwdata[ela_pkg::C_ARM];
					n.ntrig = hwdata[ela_pkg::C_NTRIG +: 2];
					n.pre = hwdata[ela_pkg::C_PRE +: 2];
					for (int i = 0; i < ela_pkg::NSTG; i++)
						n.tcfg[i].and_mode = hwdata[ela_pkg::C_AND + i];
				end
				ela_pkg::A_REQD: n.mism = (hwdata != ela_pkg::DEPTH_W);
				ela_pkg::A_STIM: n.stim_cfg = hwdata;
				ela_pkg::A_RADR: n.rd_adr = hwdata[ela_pkg::AW-1:0];
				default:
					if (adec[2])
					begin
						case (s.adr[3:2])
							ela_pkg::SUB_CARE: n.tcfg[adec[1:0]].care = hwdata;
							ela_pkg::SUB_EDGE:
								n.tcfg[adec[1:0]].edge_en = hwdata;
							default: n.tcfg[adec[1:0]].val = hwdata;
						endcase
					end
			endcase
		end

		// address phase; reads wait two cycles so a fresh
		// readback address reaches the buffer output first
		if (hsel && htrans[1] && hready)
		begin
			n.adr = haddr[7:0];
			if (hwrite)
			begin
				n.wr_pend = 1'b1;
			end
			else
			begin
				n.rd_wait = ela_pkg::RD_WAIT;
				n.hready = 1'b0;
			end
		end
		if (s.rd_wait != 2'h0)
		begin
			n.rd_wait = s.rd_wait - 2'h1;
			if (s.rd_wait == 2'h1)
			begin
				n.hrdata = rdv;
				n.hready = 1'b1;
			end
		end

		// capture sequencer
		if (arm)
		begin
			n.wp = '0;
			n.cnt = '0;
			n.stage = '0;
			n.trig = 1'b0;
			n.stim = s.stim_cfg;
			n.stim_vld = 1'b1;
			// pre-store may arrive in the arming write itself
			n.st = (n.pre == 2'h0) ? ela_pkg::ELA_HUNT
				: ela_pkg::ELA_FILL;
		end
		else
		begin
			unique case (s.st)
				ela_pkg::ELA_IDLE, ela_pkg::ELA_DONE:
				begin
					n.st = s.st;
				end
				ela_pkg::ELA_FILL:
				begin
					// trigger is not looked for until pre-store is full
					we = 1'b1;
					n.wp = s.wp + 10'h1;
					n.cnt = s.cnt + 11'h1;
					if (n.cnt == pre_n)
						n.st = ela_pkg::ELA_HUNT;
				end
				ela_pkg::ELA_HUNT:
				begin
					we = 1'b1;
					n.wp = s.wp + 10'h1;
					if (hit)
					begin
						if (s.stage == last)
						begin
							n.tpos = s.wp;
							n.trig = 1'b1;
							n.cnt = ela_pkg::DEPTH_N - pre_n - 11'h1;
							n.st = ela_pkg::ELA_POST;
						end
						else
						begin
							n.stage = s.stage + 2'h1;
						end
					end
				end
				ela_pkg::ELA_POST:
				begin
					we = 1'b1;
					n.wp = s.wp + 10'h1;
					n.cnt = s.cnt - 11'h1;
					if (s.cnt == 11'h1)
						n.st = ela_pkg::ELA_DONE;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			s <= '0;
			s.st <= ela_pkg::ELA_IDLE;
			s.ntrig <= ela_pkg::NTRIG_RST;
			s.hready <= 1'b1;
		end
		else
		begin
			s <= n;
		end
	end

	assign hreadyout = s.hready;
	assign hresp = 1'b0;
	assign hrdata = s.hrdata;
	assign stim = s.stim;
	assign stim_valid = s.stim_vld;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_stim_load;
		arm |=> stim_valid && stim == $past(s.stim_cfg);
	endproperty
	a_stim_load: assert property (p_stim_load)
		else $error("stimulus not loaded on arm");

	property p_stim_once;
		stim_valid && !arm |=> !stim_valid;
	endproperty
	a_stim_once: assert property (p_stim_once)
		else $error("stimulus valid longer than one cycle");

	property p_stage_step;
		s.st == ela_pkg::ELA_HUNT && !arm && hit && s.stage != last
		|=> s.stage == $past(s.stage) + 2'h1 && s.st == ela_pkg::ELA_HUNT;
	endproperty
	a_stage_step: assert property (p_stage_step)
		else $error("trigger stage did not advance");

	property p_hold;
		s.st == ela_pkg::ELA_DONE && !arm |=> $stable(s.wp) && !we;
	endproperty
	a_hold: assert property (p_hold)
		else $error("buffer written after capture done");

	property p_no_pre;
		arm |=> s.st == ((s.pre == 2'h0) ? ela_pkg::ELA_HUNT
			: ela_pkg::ELA_FILL);
	endproperty
	a_no_pre: assert property (p_no_pre)
		else $error("capture did not start in the pre-store state");

	property p_tpos;
		s.st == ela_pkg::ELA_HUNT && !arm && hit && s.stage == last
		|=> s.trig && s.tpos == $past(s.wp) && s.st == ela_pkg::ELA_POST;
	endproperty
	a_tpos: assert property (p_tpos)
		else $error("trigger position not recorded");

	property p_mism;
		s.wr_pend && s.adr == ela_pkg::A_REQD
		|=> s.mism == ($past(hwdata) != ela_pkg::DEPTH_W);
	endproperty
	a_mism: assert property (p_mism)
		else $error("depth mismatch flag wrong");

	property p_all_x;
		s.st == ela_pkg::ELA_HUNT && s.tcfg[s.stage].care == '0 |-> hit;
	endproperty
	a_all_x: assert property (p_all_x)
		else $error("all dont care stage did not match");

	property p_rd_wait;
		hsel && htrans[1] && hready && !hwrite
		|=> !hreadyout ##1 !hreadyout ##1 hreadyout;
	endproperty
	a_rd_wait: assert property (p_rd_wait)
		else $error("read wait states wrong");

endmodule

// File: hdl/ela_pkg.sv
// shared constants and carrier types of the embedded logic analyzer
package ela_pkg;

	// ------------------------------------------------------------
	// build-time sizes
	// ------------------------------------------------------------
	localparam int CAP_W = 32;
	localparam int AW = 10;
	localparam int STIM_W = 32;
	localparam int NSTG = 3;
	localparam logic [10:0] DEPTH_N = 11'h400;
	localparam logic [10:0] QUARTER = 11'h100;
	localparam logic [31:0] DEPTH_W = 32'h0000_0400;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STAT = 8'h04;
	localparam logic [7:0] A_REQD = 8'h08;
	localparam logic [7:0] A_TPOS = 8'h0C;
	localparam logic [7:0] A_STIM = 8'h10;
	localparam logic [7:0] A_RADR = 8'h14;
	localparam logic [7:0] A_RDAT = 8'h18;
	localparam logic [7:0] A_TRIG = 8'h20;
	localparam logic [7:0] TRIG_SPAN = 8'h30;
	localparam logic [1:0] SUB_CARE = 2'h0;
	localparam logic [1:0] SUB_EDGE = 2'h1;
	localparam logic [1:0] SUB_VAL = 2'h2;

	// ------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------
	localparam int C_ARM = 0;
	localparam int C_NTRIG = 1;
	localparam int C_PRE = 3;
	localparam int C_AND = 5;
	localparam int S_BUSY = 0;
	localparam int S_TRIG = 1;
	localparam int S_DONE = 2;
	localparam int S_MISM = 3;
	localparam int S_MARK = 4;
	localparam int S_STAGE = 8;
	localparam int T_IDX = 16;
	localparam logic [1:0] NTRIG_RST = 2'h1;
	localparam logic [1:0] RD_WAIT = 2'h2;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		ELA_IDLE = 5'h01,
		ELA_FILL = 5'h02,
		ELA_HUNT = 5'h04,
		ELA_POST = 5'h08,
		ELA_DONE = 5'h10
	} ela_cap_t;

	typedef struct packed {
		logic [CAP_W-1:0] care;
		logic [CAP_W-1:0] edge_en;
		logic [CAP_W-1:0] val;
		logic             and_mode;
	} ela_trig_cfg_t;

endpackage

// File: hdl/ela_trace_mem.sv
// trace buffer: one write port, one registered read port
`timescale 1ns/1ps
module ela_trace_mem (
	input  wire logic                    clk,
	input  wire logic                    we,
	input  wire logic [ela_pkg::AW-1:0]  waddr,
	input  wire logic [ela_pkg::CAP_W-1:0] wdata,
	input  wire logic [ela_pkg::AW-1:0]  raddr,
	output logic      [ela_pkg::CAP_W-1:0] rdata
);

	// no reset on the array: contents are only valid after a capture
	logic [ela_pkg::CAP_W-1:0] mem [0:(1<<ela_pkg::AW)-1];

	always_ff @(posedge clk)
	begin
		if (we)
		begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end

endmodule

// File: hdl/ela_trig_stage.sv
// one trigger pattern comparator, purely combinational
`timescale 1ns/1ps
module ela_trig_stage (
	input  wire ela_pkg::ela_trig_cfg_t    cfg,
	input  wire logic [ela_pkg::CAP_W-1:0] probe,
	input  wire logic [ela_pkg::CAP_W-1:0] prev,
	output logic                           match
);

	logic [ela_pkg::CAP_W-1:0] rise;
	logic [ela_pkg::CAP_W-1:0] fall;
	logic [ela_pkg::CAP_W-1:0] hit;

	// per bit: edge mode picks rise or fall by val, level compares
	assign rise = probe & ~prev;
	assign fall = ~probe & prev;
	assign hit = (cfg.edge_en & (cfg.val & rise | ~cfg.val & fall))
		| (~cfg.edge_en & ~(probe ^ cfg.val));

	// all don't care always matches, even in or mode
	assign match = (cfg.care == '0)
		| (cfg.and_mode ? &(hit | ~cfg.care)
		: |(hit & cfg.care));

endmodule

// File: tb/ela_user_model.sv
// user-design stand-in: counting probe source and stimulus sink
`timescale 1ns/1ps
module ela_user_model (
	input  wire logic                       hclk,
	input  wire logic                       hresetn,
	input  wire logic [ela_pkg::STIM_W-1:0] stim,
	input  wire logic                       stim_valid,
	output logic      [ela_pkg::CAP_W-1:0]  probe,
	output logic      [ela_pkg::STIM_W-1:0] stim_seen,
	output int                              pulses
);
	// ------------------------------------------------------------
	// probe source and stimulus capture
	// ------------------------------------------------------------
	// free-running count: every sample unique, order visible
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			probe <= 32'h0;
			stim_seen <= 32'h0;
			pulses <= 0;
		end
		else
		begin
			probe <= probe + 32'h1;
			// stimulus is only meaningful while valid is high
			if (stim_valid === 1'b1)
			begin
				stim_seen <= stim;
				pulses <= pulses + 1;
			end
		end
	end
endmodule

// File: tb/tb_embedded_logic_analyzer.sv
// self-checking bench of the embedded logic analyzer
`timescale 1ns/1ps
module tb_embedded_logic_analyzer;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic [31:0] probe;
	logic [31:0] stim;
	logic        stim_valid;
	logic [31:0] stim_seen;
	int          pulses;
	logic        rdy_n;
	logic [31:0] rd_n;
	logic [31:0] r;
	logic [31:0] t;
	int          p;
	int          miscompares;
	int          checks;
	int          cyc;

	ela_top DUT (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.hsel       (hsel),
		.haddr      (haddr),
		.htrans     (htrans),
		.hwrite     (hwrite),
		.hsize      (3'h2),
		.hwdata     (hwdata),
		.hready     (hreadyout),
		.hreadyout  (hreadyout),
		.hresp      (hresp),
		.hrdata     (hrdata),
		.probe      (probe),
		.stim       (stim),
		.stim_valid (stim_valid)
	);

	ela_user_model user (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.stim       (stim),
		.stim_valid (stim_valid),
		.probe      (probe),
		.stim_seen  (stim_seen),
		.pulses     (pulses)
	);

	// ------------------------------------------------------------
	// clock, bus sampling, timeout
	// ------------------------------------------------------------
	initial
		hclk = 1'b0;
	always #12.5 hclk = ~hclk;

	// sampled mid-cycle so a posedge sees the value before the edge
	always @(negedge hclk)
	begin
		rdy_n = hreadyout;
		rd_n = hrdata;
	end

	always @(posedge hclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			miscompares++;
			end_of_test;
		end
	end

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic end_of_test;
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one single ahb-lite transfer; read data lands in r
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		haddr <= {24'h000000, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (rdy_n !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (rdy_n !== 1'b1);
		r = rd_n;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(r, exp);
	endtask

	task automatic wait_done;
		r = 32'h0;
		while (r[ela_pkg::S_DONE] !== 1'b1)
			xfer(1'b0, ela_pkg::A_STAT, 32'h0);
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b1;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		miscompares = 0;
		checks = 0;
		cyc = 0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdchk(ela_pkg::A_CTRL, 32'h2);
		chk({31'h0, hresp}, 32'h0);
		rdchk(ela_pkg::A_STAT, 32'h0);
		rdchk(8'h1C, 32'h0);
		rdchk(ela_pkg::A_REQD, ela_pkg::DEPTH_W);
		xfer(1'b1, ela_pkg::A_REQD, 32'h200);
		rdchk(ela_pkg::A_STAT, 32'h8);
		xfer(1'b1, ela_pkg::A_REQD, ela_pkg::DEPTH_W);
		rdchk(ela_pkg::A_STAT, 32'h0);
		// all don't-care single stage, every pre-store code
		for (p = 0; p < 4; p++)
		begin
			xfer(1'b1, ela_pkg::A_STIM, 32'hA5C3_0F00 + 32'(p));
			xfer(1'b1, ela_pkg::A_CTRL, (32'(p) << 3) | 32'h3);
			wait_done;
			chk(32'(pulses), 32'(p + 1));
			chk(stim_seen, 32'hA5C3_0F00 + 32'(p));
			xfer(1'b0, ela_pkg::A_TPOS, 32'h0);
			chk({21'h0, r[26:16]}, 32'(p * 256));
			xfer(1'b1, ela_pkg::A_RADR, 32'(p * 256));
			xfer(1'b0, ela_pkg::A_RDAT, 32'h0);
			t = r;
			xfer(1'b1, ela_pkg::A_RADR, 32'h0);
			xfer(1'b0, ela_pkg::A_STAT, 32'h0);
			chk(r & 32'h1F, (p != 0) ? 32'h16 : 32'h6);
			repeat (40) @(posedge hclk);
			xfer(1'b0, ela_pkg::A_RDAT, 32'h0);
			chk(t - r, 32'(p * 256));
		end
		// three stages: and level, and rise+level, or fall/level
		xfer(1'b1, ela_pkg::A_TRIG, 32'hFF);
		xfer(1'b1, ela_pkg::A_TRIG + 8'h08, 32'h10);
		xfer(1'b1, ela_pkg::A_TRIG + 8'h10, 32'h101);
		xfer(1'b1, ela_pkg::A_TRIG + 8'h14, 32'h100);
		xfer(1'b1, ela_pkg::A_TRIG + 8'h18, 32'h100);
		xfer(1'b1, ela_pkg::A_TRIG + 8'h20, 32'h8000_0010);
		xfer(1'b1, ela_pkg::A_TRIG + 8'h24, 32'h10);
		xfer(1'b1, ela_pkg::A_TRIG + 8'h28, 32'h8000_0000);
		xfer(1'b1, ela_pkg::A_CTRL, 32'h6F);
		wait_done;
		xfer(1'b0, ela_pkg::A_TPOS, 32'h0);
		chk({21'h0, r[26:16]}, 32'h100);
		xfer(1'b1, ela_pkg::A_RADR, 32'h100);
		xfer(1'b0, ela_pkg::A_RDAT, 32'h0);
		chk({23'h0, r[8:0]}, 32'h120);
		t = r;
		xfer(1'b0, ela_pkg::A_STAT, 32'h0);
		chk({31'h0, r[ela_pkg::S_MARK]}, 32'h0);
		xfer(1'b1, ela_pkg::A_RADR, 32'hFF);
		xfer(1'b0, ela_pkg::A_RDAT, 32'h0);
		chk(t - r, 32'h1);
		xfer(1'b0, ela_pkg::A_STAT, 32'h0);
		chk({31'h0, r[ela_pkg::S_MARK]}, 32'h1);
		end_of_test;
	end
endmodule
